/* File: sram_port_regs.svh */
// Functional notes
// RL1: memory holds 131072 bytes, 17-bit address, 8 data lines.
// RL2: either select inactive leaves the memory unselected and its lines floating.
// RL3: selected with gate and strobe high: lines float, no access.
// RL4: selected, gate low, strobe high: memory drives the addressed byte.
// RL5: selected with strobe low: memory takes data lines as write input.
// RL6: write lasts only while low select and strobe low, high select high.
// RL7: controller keeps every read cycle at least 120 ns long.
// RL8: read data valid at most 120 ns after stable address or select.
// RL9: read data valid at most 60 ns after gate falls.
// RL10: old read data holds at least 10 ns after address change.
// RL11: memory drives no earlier than 10 ns after select, 5 ns after gate.
// RL12: memory floats within 40 ns of deselect, 35 ns of gate rising.
// RL13: controller holds address and selects 100 ns before write ends.
// RL14: controller holds strobe low 70 ns; address may come with zero setup.
// RL15: controller drives write data 50 ns before write end; zero hold allowed.
// RL16: write recovery before next address change may be zero.
// RL17: memory floats within 40 ns of strobe falling; drives 5 ns after write.
// RL18: controller never drives data lines while memory drives them.
// RL19: deselect before retention; stay deselected 5 ns after supply recovery.
// RL20: faster grade on narrow supply completes 85 ns cycles.
// RL21: reads return last written byte; contents persist while idle.
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define ADDR_WIDTH 17
`define DATA_WIDTH 8
`define MEM_DEPTH 131072

// ----------------------------------------
// timing, ns, slower grade wide supply so both grades are met
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define READ_CYCLE_MIN_NS 120
`define ADDRESS_TO_DATA_MAX_NS 120
`define GATE_OFF_TO_FLOAT_MAX_NS 35
`define DESELECT_TO_FLOAT_MAX_NS 40
`define ADDRESS_TO_WRITE_END_NS 100
`define WRITE_PULSE_MIN_NS 70
`define DATA_SETUP_TO_WRITE_END_NS 50
`define DRIVE_AFTER_WRITE_MIN_NS 5
`define RETENTION_EXIT_RECOVERY_NS 5

// least times round up, a sample point after a max also rounds up
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC `NS_TO_CYC(`READ_CYCLE_MIN_NS)
`define READ_SAMPLE_CYC `NS_TO_CYC(`ADDRESS_TO_DATA_MAX_NS)
`define FLOAT_CYC `NS_TO_CYC(`DESELECT_TO_FLOAT_MAX_NS)
`define WRITE_CYC `NS_TO_CYC(`ADDRESS_TO_WRITE_END_NS)
`define RECOVER_CYC `NS_TO_CYC(`RETENTION_EXIT_RECOVERY_NS)
`define CNT_WIDTH 5

`endif

/* File: sram_port_pkg.sv */
package sram_port_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_read,
        st_float,
        st_write,
        st_retain,
        st_recover
    } ctrl_state_type;
endpackage : sram_port_pkg

/* File: sram_timer_if.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_regs.svh"
interface sram_timer_if;
    logic load;
    logic [`CNT_WIDTH-1:0] value;
    logic expired;
    modport ctrl (output load, output value, input expired);
    modport timer (input load, input value, output expired);
endinterface : sram_timer_if
`default_nettype wire

/* File: sram_cycle_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_regs.svh"
// ----------------------------------------
// down counter for pin timing
// ----------------------------------------
module sram_cycle_timer (
    input wire logic sys_clk,
    input wire logic reset,
    sram_timer_if.timer tmr
);
    logic [`CNT_WIDTH-1:0] count_ff;
    wire logic [`CNT_WIDTH-1:0] nxt_count;

    assign nxt_count = tmr.load ? tmr.value : ((count_ff != '0) ? count_ff - `CNT_WIDTH'h1 : count_ff);
    // no load term: the controller's load depends on expired, which would close a loop
    assign tmr.expired = (count_ff == `CNT_WIDTH'h1);

    always_ff @(posedge sys_clk) begin
        if (reset) count_ff <= '0;
        else count_ff <= nxt_count;
    end
endmodule : sram_cycle_timer
`default_nettype wire

/* File: sram_port_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_regs.svh"
// ----------------------------------------
// host side sequencer for the static memory port
// ----------------------------------------
module sram_port_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    // user side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`ADDR_WIDTH-1:0] req_addr,
    input wire logic [`DATA_WIDTH-1:0] req_wdata,
    output logic rsp_valid,
    output logic [`DATA_WIDTH-1:0] rsp_rdata,
    input wire logic retain_req,
    output logic retain_ack,
    // memory pins
    output logic [`ADDR_WIDTH-1:0] word_address,
    output logic select_low_active_n,
    output logic select_high_active,
    output logic gate_n,
    output logic strobe_n,
    input wire logic [`DATA_WIDTH-1:0] byte_lines_in,
    output logic [`DATA_WIDTH-1:0] byte_lines_out,
    output logic byte_lines_oe_n
);
    sram_port_pkg::ctrl_state_type state_ff, nxt_state;
    logic [`ADDR_WIDTH-1:0] addr_ff;
    logic [`DATA_WIDTH-1:0] wdata_ff;
    logic [`DATA_WIDTH-1:0] rdata_ff;
    logic rsp_ff;
    logic [`CNT_WIDTH-1:0] elapsed_ff;

    sram_timer_if tmr_bus ();

    sram_cycle_timer u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .tmr(tmr_bus.timer)
    );

    function automatic logic [`CNT_WIDTH-1:0] cyc(input int n);
        cyc = n[`CNT_WIDTH-1:0];
    endfunction : cyc

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic is_idle = (state_ff == sram_port_pkg::st_idle);
    wire logic start_read = is_idle && req_valid && !req_write && !retain_req;
    wire logic start_write = is_idle && req_valid && req_write && !retain_req;
    wire logic start_retain = is_idle && retain_req;
    wire logic in_read = (state_ff == sram_port_pkg::st_read);
    wire logic in_write = (state_ff == sram_port_pkg::st_write);
    wire logic deselected = (state_ff == sram_port_pkg::st_retain) || (state_ff == sram_port_pkg::st_recover);
    // sample once address-to-data has surely passed, still inside the cycle
    wire logic sample_now = in_read && (elapsed_ff == cyc(`READ_SAMPLE_CYC - 1));
    wire logic timer_done = tmr_bus.expired;

    assign req_ready = is_idle && !retain_req;
    assign retain_ack = (state_ff == sram_port_pkg::st_retain);
    assign tmr_bus.load = start_read | start_write | (in_read & timer_done) | start_retain
        | ((state_ff == sram_port_pkg::st_retain) & !retain_req);
    assign tmr_bus.value = start_read ? cyc(`READ_CYC) :
                           start_write ? cyc(`WRITE_CYC) :
                           (in_read & timer_done) ? cyc(`FLOAT_CYC) :
                           start_retain ? cyc(1) : cyc(`RECOVER_CYC);

    // ----------------------------------------
    // state sequence
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sram_port_pkg::st_idle: begin
                if (start_retain) nxt_state = sram_port_pkg::st_retain; // RL19
                else if (start_read) nxt_state = sram_port_pkg::st_read; // RL4
                else if (start_write) nxt_state = sram_port_pkg::st_write; // RL5
            end
            sram_port_pkg::st_read: begin
                if (timer_done) nxt_state = sram_port_pkg::st_float; // RL7
            end
            // bus turnaround: the memory may drive up to 40 ns after deselect
            sram_port_pkg::st_float: begin
                if (timer_done) nxt_state = sram_port_pkg::st_idle; // RL12 RL18
            end
            sram_port_pkg::st_write: begin
                if (timer_done) nxt_state = sram_port_pkg::st_idle; // RL13 RL14 RL16
            end
            sram_port_pkg::st_retain: begin
                if (!retain_req) nxt_state = sram_port_pkg::st_recover;
            end
            sram_port_pkg::st_recover: begin
                if (timer_done) nxt_state = sram_port_pkg::st_idle; // RL19
            end
            default: nxt_state = sram_port_pkg::st_idle;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) state_ff <= sram_port_pkg::st_idle;
        else state_ff <= nxt_state;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) elapsed_ff <= '0;
        else if (start_read) elapsed_ff <= '0;
        else if (in_read && elapsed_ff != '1) elapsed_ff <= elapsed_ff + `CNT_WIDTH'h1;
    end

    // address and data stay stable for the whole cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_ff <= '0;
            wdata_ff <= '0;
        end else if (start_read || start_write) begin
            addr_ff <= req_addr; // RL14
            wdata_ff <= req_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_ff <= '0;
            rsp_ff <= 1'b0;
        end else begin
            rsp_ff <= sample_now; // RL8
            if (sample_now) rdata_ff <= byte_lines_in; // RL8 RL21
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign word_address = addr_ff;
    // selects stay asserted through both read and write; retention holds them off
    assign select_low_active_n = !(in_read || in_write); // RL2 RL6 RL19
    assign select_high_active = !deselected; // RL19
    assign gate_n = !in_read; // RL3 RL4
    assign strobe_n = !in_write; // RL6 RL14
    assign byte_lines_out = wdata_ff; // RL15
    // drive only while writing, strobe low keeps the memory off the lines
    assign byte_lines_oe_n = !in_write; // RL18 RL15
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rdata_ff;
endmodule : sram_port_ctrl
`default_nettype wire

/* File: sram_async_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_regs.svh"
// ----------------------------------------
// behavioural static memory
// ----------------------------------------
module sram_async_model #(parameter int ACC_NS = 119) (
    input wire logic [`ADDR_WIDTH-1:0] word_address,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic gate_n,
    input wire logic strobe_n,
    input wire logic [`DATA_WIDTH-1:0] byte_lines_out,
    input wire logic byte_lines_oe_n,
    output logic [`DATA_WIDTH-1:0] byte_lines_in
);
    logic [7:0] mem [int];
    wire logic sel = !select_low_active_n && select_high_active;
    wire logic rd = sel && !gate_n && strobe_n;
    wire logic wr = sel && !strobe_n;
    initial byte_lines_in = 8'h00;
    // only a driven byte is stored, so lines released with the strobe cannot race in garbage
    always @* if (wr && !byte_lines_oe_n) mem[word_address] = byte_lines_out;
    // lines still undriven shortly after a write starts leave a wrong byte behind
    always @(posedge wr) #1 if (wr && byte_lines_oe_n) mem[word_address] = 8'h5A;
    always @(word_address or rd) begin
        byte_lines_in <= ~byte_lines_in;
        if (rd) byte_lines_in <= #(ACC_NS) (mem.exists(word_address) ? mem[word_address] : 8'h00);
    end
endmodule : sram_async_model
`default_nettype wire

/* File: sram_port_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_regs.svh"
module sram_port_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic rsp_valid,
    input wire logic retain_ack,
    input wire logic [`ADDR_WIDTH-1:0] word_address,
    input wire logic select_low_active_n,
    input wire logic select_high_active,
    input wire logic gate_n,
    input wire logic strobe_n,
    input wire logic [`DATA_WIDTH-1:0] byte_lines_out,
    input wire logic byte_lines_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    read_len_a: assert property ($fell(gate_n) |-> (!gate_n && !select_low_active_n)[*8] ##1 !gate_n[*4])
        else $error("read cycle too short");
    rsp_time_a: assert property (req_valid && req_ready && !req_write |-> ##13 rsp_valid)
        else $error("read answer late");
    no_fight_a: assert property (!gate_n |-> byte_lines_oe_n)
        else $error("drive during read");
    wr_pulse_a: assert property ($fell(strobe_n) |-> (!strobe_n && !byte_lines_oe_n)[*7])
        else $error("write strobe short");
    wr_select_a: assert property ($fell(strobe_n) |-> (!select_low_active_n && select_high_active)[*8] ##1 !strobe_n[*2])
        else $error("write select short");
    wr_data_a: assert property ($fell(strobe_n) |=> ($stable(byte_lines_out) && $stable(word_address))[*6])
        else $error("write data moved");
    retain_off_a: assert property (retain_ack |-> !select_high_active && select_low_active_n && strobe_n)
        else $error("selected in retention");
    recover_a: assert property ($rose(select_high_active) |-> select_low_active_n)
        else $error("no recovery gap");
    rd_addr_a: assert property (!gate_n && !$past(gate_n) |-> $stable(word_address))
        else $error("address moved in read");
endmodule : sram_port_monitor
bind sram_port_ctrl sram_port_monitor u_mon (.sys_clk, .reset, .req_valid, .req_ready, .req_write, .rsp_valid,
    .retain_ack, .word_address, .select_low_active_n, .select_high_active, .gate_n, .strobe_n, .byte_lines_out,
    .byte_lines_oe_n);
`default_nettype wire

/* File: async_sram_128k_by_8_port_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sram_port_regs.svh"
module async_sram_128k_by_8_port_tb_top;
    logic sys_clk = 0, reset = 1, req_valid = 0, req_write = 0, retain_req = 0;
    logic [16:0] req_addr = '0, wa;
    logic [7:0] req_wdata = '0, rsp_rdata, bl_in, bl_out;
    logic req_ready, rsp_valid, retain_ack, sel_n, sel_h, gate_n, strobe_n, oe_n;
    logic [31:0] seed = 32'hC68FF7B9;
    logic [7:0] exp_mem [int];
    logic [16:0] aq [$];
    int fails = 0, n_tests = 0, i;
    always #5 sys_clk = ~sys_clk;
    sram_port_ctrl DUT (.sys_clk, .reset, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid,
        .rsp_rdata, .retain_req, .retain_ack, .word_address(wa), .select_low_active_n(sel_n),
        .select_high_active(sel_h), .gate_n, .strobe_n, .byte_lines_in(bl_in), .byte_lines_out(bl_out),
        .byte_lines_oe_n(oe_n));
    sram_async_model mem_model (.word_address(wa), .select_low_active_n(sel_n), .select_high_active(sel_h),
        .gate_n, .strobe_n, .byte_lines_out(bl_out), .byte_lines_oe_n(oe_n), .byte_lines_in(bl_in));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        xs = s;
    endfunction : xs
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("checks=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // which: 0 request ready, 1 read answer, 2 retention acknowledge
    task wait_hi(input int which);
        int k;
        k = 0;
        do @(negedge sys_clk);
        while ((which == 0 ? req_ready : which == 1 ? rsp_valid : retain_ack) !== 1'b1 && ++k < 60);
        if (k >= 60) begin
            fails++;
            wrap_up;
        end
    endtask : wait_hi
    task op(input logic w, input logic [16:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req_valid <= 1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        wait_hi(0);
        @(posedge sys_clk);
        req_valid <= 0;
        if (w) exp_mem[a] = d;
        else begin
            wait_hi(1);
            chk(rsp_rdata, exp_mem[a]);
        end
    endtask : op
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        #500us;
        fails++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 0;
        for (i = 0; i < 12; i++) begin
            seed = xs(seed);
            aq.push_back(i < 2 ? {17{i[0]}} : seed[16:0]);
            op(1, aq[i], seed[24:17]);
            if (i == 5) op(0, aq[i], 8'h00);
        end
        foreach (aq[j]) op(0, aq[j], 8'h00);
        @(posedge sys_clk);
        retain_req <= 1;
        wait_hi(2);
        chk({sel_h, sel_n, req_ready}, 3'b010);
        @(posedge sys_clk);
        retain_req <= 0;
        for (i = 0; i < 4; i++) op(0, aq[i], 8'h00);
        // mid-run reset: pins return to idle levels, memory contents survive
        @(posedge sys_clk);
        reset <= 1;
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        @(negedge sys_clk);
        chk({wa, sel_n, sel_h, gate_n, strobe_n, oe_n, rsp_valid, req_ready}, 24'h00007D);
        op(0, aq[0], 8'h00);
        wrap_up;
    end
endmodule : async_sram_128k_by_8_port_tb_top
`default_nettype wire
